// [tb/ssw_checker.sv]
`timescale 1ns/1ns
module ssw_checker (
  input wire clk, // clock
  input wire reset, // sync reset
  input wire supply_below_reset, // supply low
  input wire supply_below_batt, // under battery
  input wire power_fail_sense_in, // sense
  input wire manual_reset_in_n, // manual reset
  input wire chip_enable_in_n, // enable in
  input wire power_fail_flag_out, // pf flag
  input wire reset_out_n, // reset out
  input wire watchdog_fault_level_n, // fault level
  input wire watchdog_fault_pulse_n, // fault pulse
  input wire chip_enable_out_n // enable out
);
  wire on_batt = supply_below_reset & supply_below_batt;
  wire pf_want = power_fail_sense_in & ~on_batt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_PF_FLAG:
    assert property (!$past(reset) |-> power_fail_flag_out == $past(pf_want))
    else $error("power-fail flag wrong");
  AST_RST_LOW:
    assert property (supply_below_reset |=> !reset_out_n)
    else $error("reset missing on low supply");
  AST_FAULT_HI:
    assert property (!reset_out_n && !$past(reset_out_n) |->
      watchdog_fault_level_n) else $error("fault level low in reset");
  AST_LEAD:
    assert property ($fell(watchdog_fault_level_n) |-> !watchdog_fault_pulse_n
      && !$past(watchdog_fault_pulse_n, 9) && $past(watchdog_fault_pulse_n, 10))
    else $error("pulse lead wrong");
  AST_PULSE_W:
    assert property ($fell(watchdog_fault_pulse_n) |->
      !watchdog_fault_pulse_n [*8]) else $error("fault pulse too short");
  AST_CE_GATE:
    assert property ($fell(chip_enable_out_n) |->
      !$past(chip_enable_in_n) && $past(reset_out_n))
    else $error("enable passed while gated");
  AST_CE_HOLD:
    assert property ($fell(reset_out_n) |-> ##[0:12] chip_enable_out_n)
    else $error("enable held too long");
  AST_MR_PROP:
    assert property (!manual_reset_in_n [*6] |=> !reset_out_n)
    else $error("manual reset ignored");
endmodule // ssw_checker
bind ssw_supervisor ssw_checker u_chk (.*);

// [tb/ssw_host_model.sv]
`timescale 1ns/1ns
module ssw_host_model (
  input wire clk, // system clock
  input wire [1:0] mode, // 0 stuck, 1 toggling, 2 floating
  input wire watchdog_fault_level_n, // fault level
  input wire watchdog_fault_pulse_n, // fault pulse
  output reg [1:0] activity_strobe_in = 2'h2, // strobe level
  output reg halt_n = 1'b1 // outside latch, low after two faults
);
  reg [4:0] cnt = 5'h00;
  // a 32-cycle level keeps well clear of the minimum width
  always @(posedge clk) begin
    cnt <= cnt + 5'h01;
    if (mode != 2'h1)
      activity_strobe_in <= mode;
    else if (cnt == 5'h00)
      activity_strobe_in <= {1'b0, ~activity_strobe_in[0]};
  end
  // data is the level, so the first fault clocks in a high
  always @(negedge watchdog_fault_pulse_n)
    halt_n <= watchdog_fault_level_n;
endmodule // ssw_host_model

// [tb/test_ssw_supervisor.sv]
`timescale 1ns/1ns
module test_ssw_supervisor;
  reg clk = 0, reset, supply_below_reset, supply_below_batt, supply_low_line;
  reg power_fail_sense_in, manual_reset_in_n, chip_enable_in_n;
  reg [1:0] mode;
  wire [1:0] activity_strobe_in;
  wire battery_active_flag, power_fail_flag_out, early_supply_warning_n;
  wire reset_out_n, watchdog_fault_level_n, watchdog_fault_pulse_n;
  wire strobe_bias_en, chip_enable_out_n, halt_n;
  integer errors = 0, checked = 0, n;
  // short timing so every path fits a short run
  localparam [31:0] T_RST_CYC = 32'h0000_0032;
  localparam [31:0] T_WD_CYC = 32'h0000_00C8;
  localparam [31:0] T_PULSE_CYC = 32'h0000_0014;
  localparam [31:0] T_CE_CYC = 32'h0000_000A;
  localparam [31:0] T_MR_MIN_CYC = 32'h0000_0008;
  localparam [31:0] T_MR_PROP_CYC = 32'h0000_0004;
  // capacitor timeouts run far too long to simulate; internal one is used
  reg timeout_select_in = 1'b1;
  reg [7:0] timing_cap_nf = 8'h00;
  ssw_supervisor #(
    .RESET_DELAY_CYC(T_RST_CYC), .WD_TIMEOUT_CYC(T_WD_CYC),
    .PULSE_CYC(T_PULSE_CYC), .CE_HOLD_CYC(T_CE_CYC),
    .MR_MIN_CYC(T_MR_MIN_CYC), .MR_PROP_CYC(T_MR_PROP_CYC)
  ) DUT (
    .clk, .reset, .supply_below_reset, .supply_below_batt, .supply_low_line,
    .power_fail_sense_in, .manual_reset_in_n, .timeout_select_in,
    .timing_cap_nf, .activity_strobe_in, .chip_enable_in_n,
    .battery_active_flag, .power_fail_flag_out, .early_supply_warning_n,
    .reset_out_n, .watchdog_fault_level_n, .watchdog_fault_pulse_n,
    .strobe_bias_en, .chip_enable_out_n);
  ssw_host_model host (.clk, .mode, .watchdog_fault_level_n,
    .watchdog_fault_pulse_n, .activity_strobe_in, .halt_n);
  task step(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task check(input [7:0] seen, input [7:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      errors = errors + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("%0d checks, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task t_power;
    supply_below_reset = 1;
    supply_below_batt = 1;
    step(2);
    check(battery_active_flag, 1);
    check(power_fail_flag_out, 0);
    check(early_supply_warning_n, 0);
    check(strobe_bias_en, 0);
    supply_below_batt = 0;
    step(2);
    check(battery_active_flag, 0);
    check(reset_out_n, 0);
    supply_below_reset = 0;
    power_fail_sense_in = 0;
    step(40);
    check(reset_out_n, 0);
    check(power_fail_flag_out, 0);
    power_fail_sense_in = 1;
    step(20);
    check(reset_out_n, 1);
    check(early_supply_warning_n, 1);
    supply_low_line = 1;
    step(2);
    check(early_supply_warning_n, 0);
    check(reset_out_n, 1);
    supply_low_line = 0;
    $display("power test done");
  endtask
  task t_mr_ce;
    chip_enable_in_n = 0;
    step(2);
    check(chip_enable_out_n, 0);
    manual_reset_in_n = 0;
    step(6);
    check(reset_out_n, 0);
    check(chip_enable_out_n, 0);
    step(12);
    check(chip_enable_out_n, 1);
    manual_reset_in_n = 1;
    step(40);
    check(reset_out_n, 0);
    step(20);
    check(reset_out_n, 1);
    chip_enable_in_n = 1;
    $display("manual reset test done");
  endtask
  task t_wd;
    mode = 2'h0;
    for (n = 0; n < 300 && watchdog_fault_pulse_n !== 1'b0; n = n + 1)
      step(1);
    check(watchdog_fault_pulse_n, 0);
    check(watchdog_fault_level_n, 1);
    step(40);
    for (n = 0; n < 300 && watchdog_fault_pulse_n !== 1'b0; n = n + 1)
      step(1);
    check(watchdog_fault_level_n, 0);
    check(halt_n, 0);
    mode = 2'h1;
    step(60);
    check(watchdog_fault_level_n, 1);
    mode = 2'h2;
    n = 0;
    repeat (450) begin
      step(1);
      n = n + (watchdog_fault_pulse_n !== 1'b1);
    end
    check(n != 0, 0);
    $display("watchdog test done");
  endtask
  initial forever #4 clk = ~clk;
  // about two and a half times the expected length of all tests
  initial begin
    repeat (3000) @(posedge clk);
    errors = errors + 1;
    summarize;
  end
  initial begin
    {reset, supply_below_reset, supply_below_batt, supply_low_line} = 4'h8;
    {power_fail_sense_in, manual_reset_in_n, chip_enable_in_n} = 3'h7;
    mode = 2'h2;
    repeat (6) @(posedge clk);
    step(1);
    reset = 0;
    step(60);
    t_power;
    t_mr_ce;
    t_wd;
    summarize;
  end
endmodule // test_ssw_supervisor

// [verilog/ssw_consts.vh]
`ifndef SSW_CONSTS_VH
`define SSW_CONSTS_VH
// clock period in ns (125 MHz)
`define SSW_CLK_NS 8
// timing figures in their own units
`define SSW_RESET_DELAY_MS 200
`define SSW_WD_TIMEOUT_MS 1600
`define SSW_WD_NS_PER_NF 2100000
`define SSW_PULSE_MS 1
`define SSW_LEAD_NS 70
`define SSW_CE_HOLD_US 15
`define SSW_MR_MIN_US 25
`define SSW_MR_PROP_US 7
`define SSW_STROBE_MIN_NS 100
// derived cycle counts
`define SSW_RESET_DELAY_CYC (`SSW_RESET_DELAY_MS * 1000000 / `SSW_CLK_NS)
`define SSW_WD_TIMEOUT_CYC (`SSW_WD_TIMEOUT_MS * 1000000 / `SSW_CLK_NS)
`define SSW_PULSE_CYC ((`SSW_PULSE_MS * 1000000 + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`define SSW_LEAD_CYC ((`SSW_LEAD_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`define SSW_CE_HOLD_CYC (`SSW_CE_HOLD_US * 1000 / `SSW_CLK_NS)
`define SSW_MR_MIN_CYC ((`SSW_MR_MIN_US * 1000 + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`define SSW_MR_PROP_CYC (`SSW_MR_PROP_US * 1000 / `SSW_CLK_NS)
`define SSW_STROBE_MIN_CYC ((`SSW_STROBE_MIN_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
// strobe level codes
`define SSW_LVL_LOW 2'h0
`define SSW_LVL_HIGH 2'h1
`define SSW_LVL_MID 2'h2
`define SSW_CNT_W 32
`endif

// [verilog/ssw_supervisor.v]
// Function
// - battery supplies output only when supply below reset and below battery.
// - battery indicator high on battery, low on main supply.
// - power-fail flag follows sense comparator; touches nothing else.
// - timeout 1.6 s internal, or 2.1 ms per nF with capacitor.
// - reset held while manual reset low, plus 200 ms after release.
// - early warning low when supply within 150 mV of reset threshold.
// - strobe has three levels; mid level disables watchdog, fault stays high.
// - strobe stuck past timeout drives fault low until next transition.
// - gated enable low only with enable low and supply ok; 15 us hold.
// - fault level forced high while reset asserted.
// - reset low under supply threshold, then 200 ms after recovery.
// - fault pulse low at least 1 ms, leading fault level by 70 ns.
// - manual reset of 25 us clears counters, outputs high, internal timeout.
// - reset asserts about 7 us after manual reset goes low.
// - strobe changes of 100 ns or more restart the watchdog timer.
// - under reset threshold watchdog off, strobe high-z, fault high.
// - battery switchover never alters reset timing.
// - battery mode forces power-fail low, ignores manual reset and select.
`timescale 1ns/1ns
`include "ssw_consts.vh"
module ssw_supervisor #(
  parameter [31:0] RESET_DELAY_CYC = `SSW_RESET_DELAY_CYC,
  parameter [31:0] WD_TIMEOUT_CYC = `SSW_WD_TIMEOUT_CYC,
  parameter [31:0] PULSE_CYC = `SSW_PULSE_CYC,
  parameter [31:0] CE_HOLD_CYC = `SSW_CE_HOLD_CYC,
  parameter [31:0] MR_MIN_CYC = `SSW_MR_MIN_CYC,
  parameter [31:0] MR_PROP_CYC = `SSW_MR_PROP_CYC
) (
  input wire clk, // 125 MHz clock
  input wire reset, // synchronous, active high
  input wire supply_below_reset, // main supply under reset threshold
  input wire supply_below_batt, // main supply under battery voltage
  input wire supply_low_line, // main supply within low-line margin
  input wire power_fail_sense_in, // high when sense above its threshold
  input wire manual_reset_in_n, // manual reset level, active low
  input wire timeout_select_in, // high: internal timeout; low: capacitor
  input wire [7:0] timing_cap_nf, // capacitor value in nF
  input wire [1:0] activity_strobe_in, // decoded strobe level
  input wire chip_enable_in_n, // memory enable from processor
  output reg battery_active_flag, // high while on battery
  output reg power_fail_flag_out, // low while sense below threshold
  output reg early_supply_warning_n, // low-line warning, active low
  output reg reset_out_n, // processor reset, active low
  output reg watchdog_fault_level_n, // watchdog fault level, active low
  output reg watchdog_fault_pulse_n, // watchdog fault pulse, active low
  output reg strobe_bias_en, // strobe input bias network connected
  output reg chip_enable_out_n // gated memory enable
);

  // ****************************************************
  // helpers
  // ****************************************************
  function [31:0] sat_inc;
    input [31:0] v;
    begin
      sat_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
    end
  endfunction

  // cnt is the value before this edge; true on the edge that makes it lim
  function reached;
    input [31:0] cnt;
    input [31:0] lim;
    begin
      reached = (cnt + 32'h0000_0001 >= lim);
    end
  endfunction

  // capacitor timeout in cycles; done wide so 255 nF cannot overflow
  function [31:0] cap_to_cycles;
    input [7:0] nf;
    reg [39:0] wide;
    begin
      wide = ({32'h0000_0000, nf} * `SSW_WD_NS_PER_NF) / `SSW_CLK_NS;
      cap_to_cycles = wide[31:0];
    end
  endfunction

  // ****************************************************
  // fixed timing
  // ****************************************************
  // the 70 ns lead rounds up to whole cycles, so it is never shorter
  localparam [31:0] LEAD_CYC = `SSW_LEAD_CYC;
  // strobe levels shorter than this are glitches, not activity
  localparam [31:0] STROBE_MIN_CYC = `SSW_STROBE_MIN_CYC;

  // ****************************************************
  // supply source and comparators
  // ****************************************************
  wire on_batt = supply_below_reset & supply_below_batt;
  // manual reset counts only off battery
  wire mr_low = ~manual_reset_in_n & ~on_batt;

  always @(posedge clk) begin
    if (reset) begin
      battery_active_flag <= 1'b0;
      power_fail_flag_out <= 1'b0;
      early_supply_warning_n <= 1'b0;
      strobe_bias_en <= 1'b0;
    end else begin
      battery_active_flag <= on_batt;
      // comparator is independent of all else, but dead on battery
      power_fail_flag_out <= power_fail_sense_in & ~on_batt;
      early_supply_warning_n <= ~supply_low_line & ~supply_below_reset;
      strobe_bias_en <= ~supply_below_reset;
    end
  end

  // ****************************************************
  // manual reset filtering
  // ****************************************************
  reg [31:0] mr_cnt;
  reg mr_long;
  always @(posedge clk) begin
    if (reset) begin
      mr_cnt <= 32'h0000_0000;
      mr_long <= 1'b0;
    end else if (mr_low) begin
      mr_cnt <= sat_inc(mr_cnt);
      if (reached(mr_cnt, MR_MIN_CYC)) mr_long <= 1'b1;
    end else begin
      mr_cnt <= 32'h0000_0000;
      mr_long <= 1'b0;
    end
  end
  wire mr_assert = mr_low && (mr_cnt >= MR_PROP_CYC);

  // ****************************************************
  // reset generator
  // ****************************************************
  // battery state is not looked at here on purpose
  // any cause restarts the delay, so a bouncing button or a brown-out
  // that recovers briefly still yields one full-length reset
  wire rst_cause = supply_below_reset | mr_assert;
  reg [31:0] rst_cnt;
  always @(posedge clk) begin
    if (reset) begin
      rst_cnt <= 32'h0000_0000;
      reset_out_n <= 1'b0;
    end else if (rst_cause) begin
      rst_cnt <= 32'h0000_0000;
      reset_out_n <= 1'b0;
    end else if (!reset_out_n) begin
      rst_cnt <= sat_inc(rst_cnt);
      if (reached(rst_cnt, RESET_DELAY_CYC))
        reset_out_n <= 1'b1;
    end
  end

  // ****************************************************
  // watchdog
  // ****************************************************
  localparam [3:0] WD_IDLE = 4'h1;
  localparam [3:0] WD_RUN = 4'h2;
  localparam [3:0] WD_LEAD = 4'h4;
  localparam [3:0] WD_FAULT = 4'h8;

  reg [3:0] wd_state;
  reg [31:0] wd_cnt;
  reg [31:0] pulse_cnt;
  reg [1:0] last_lvl;
  reg [1:0] cand_lvl;
  reg [7:0] cand_cnt;
  reg use_cap;

  // ****************************************************
  // strobe qualifier
  // ****************************************************
  // a level change only counts once stable for the minimum duration
  // limitation: a pulse narrower than that is invisible to the watchdog
  wire lvl_valid = (activity_strobe_in != `SSW_LVL_MID);
  wire strobe_edge = lvl_valid && (activity_strobe_in == cand_lvl) &&
    (cand_lvl != last_lvl) &&
    reached({24'h00_0000, cand_cnt}, STROBE_MIN_CYC);
  wire [31:0] cap_cyc = cap_to_cycles(timing_cap_nf);
  wire [31:0] timeout = use_cap ? cap_cyc : WD_TIMEOUT_CYC;
  wire wd_off = !reset_out_n || supply_below_reset ||
    (activity_strobe_in == `SSW_LVL_MID) || mr_long;

  always @(posedge clk) begin
    if (reset) begin
      cand_lvl <= `SSW_LVL_MID;
      cand_cnt <= 8'h00;
    end else if (activity_strobe_in != cand_lvl) begin
      cand_lvl <= activity_strobe_in;
      cand_cnt <= 8'h00;
    end else if (cand_cnt != 8'hFF) begin
      cand_cnt <= cand_cnt + 8'h01;
    end
  end

  // ****************************************************
  // timeout select
  // ****************************************************
  // choice is frozen on battery, so a dying select pin cannot flip it
  always @(posedge clk) begin
    if (reset || mr_long) begin
      use_cap <= 1'b0;
    end else if (!on_batt && !strobe_bias_en) begin
      use_cap <= 1'b0;
    end else if (!on_batt) begin
      use_cap <= ~timeout_select_in;
    end
  end

  // ****************************************************
  // watchdog state machine
  // ****************************************************
  // pulse falls first and the level follows, so an outside flip-flop
  // clocked by the pulse samples the level while it is still high
  always @(posedge clk) begin
    if (reset || wd_off) begin
      wd_state <= WD_IDLE;
      wd_cnt <= 32'h0000_0000;
      pulse_cnt <= 32'h0000_0000;
      watchdog_fault_level_n <= 1'b1;
      watchdog_fault_pulse_n <= 1'b1;
      last_lvl <= lvl_valid ? activity_strobe_in : `SSW_LVL_MID;
    end else begin
      if (strobe_edge) last_lvl <= cand_lvl;
      if (watchdog_fault_pulse_n == 1'b0) begin
        pulse_cnt <= sat_inc(pulse_cnt);
        if (reached(pulse_cnt, PULSE_CYC))
          watchdog_fault_pulse_n <= 1'b1;
      end
      case (wd_state)
        WD_IDLE: begin
          wd_cnt <= 32'h0000_0000;
          wd_state <= WD_RUN;
        end
        WD_RUN: begin
          if (strobe_edge) begin
            wd_cnt <= 32'h0000_0000;
          end else if (reached(wd_cnt, timeout)) begin
            wd_cnt <= 32'h0000_0000;
            pulse_cnt <= 32'h0000_0000;
            watchdog_fault_pulse_n <= 1'b0;
            wd_state <= WD_LEAD;
          end else begin
            wd_cnt <= sat_inc(wd_cnt);
          end
        end
        WD_LEAD: begin
          wd_cnt <= sat_inc(wd_cnt);
          if (reached(wd_cnt, LEAD_CYC)) begin
            watchdog_fault_level_n <= 1'b0;
            wd_cnt <= 32'h0000_0000;
            wd_state <= WD_FAULT;
          end
        end
        WD_FAULT: begin
          if (strobe_edge) begin
            watchdog_fault_level_n <= 1'b1;
            wd_cnt <= 32'h0000_0000;
            wd_state <= WD_RUN;
          end else if (reached(wd_cnt, timeout)) begin
            // still stuck: pulse again so an outside latch sees a 2nd fault
            wd_cnt <= 32'h0000_0000;
            pulse_cnt <= 32'h0000_0000;
            watchdog_fault_pulse_n <= 1'b0;
          end else begin
            wd_cnt <= sat_inc(wd_cnt);
          end
        end
        default: wd_state <= WD_IDLE;
      endcase
    end
  end

  // ****************************************************
  // chip-enable gating
  // ****************************************************
  // a memory cycle already under way may finish, so a write is not cut
  // in half; a new cycle cannot start once reset or low supply is seen
  reg [31:0] ce_cnt;
  always @(posedge clk) begin
    if (reset) begin
      ce_cnt <= 32'h0000_0000;
      chip_enable_out_n <= 1'b1;
    end else if (mr_long || chip_enable_in_n) begin
      ce_cnt <= 32'h0000_0000;
      chip_enable_out_n <= 1'b1;
    end else if (reset_out_n && !supply_below_reset) begin
      ce_cnt <= 32'h0000_0000;
      chip_enable_out_n <= 1'b0;
    end else if (!chip_enable_out_n) begin
      // active cycle survives reset for at most the hold time
      ce_cnt <= sat_inc(ce_cnt);
      if (reached(ce_cnt, CE_HOLD_CYC))
        chip_enable_out_n <= 1'b1;
    end
  end

endmodule // ssw_supervisor
